// ### hdl/rcf_pkg.sv
// package: register map, field positions and reset values of the reset-cause block
package rcf_pkg;
   // register byte addresses
   localparam logic [7:0] CAUSE_OFF  = 8'h00;
   localparam logic [7:0] IRQ_STAT_OFF = 8'h04;
   localparam logic [7:0] IRQ_CLR_OFF  = 8'h08;
   localparam logic [7:0] IRQ_EN_OFF   = 8'h0C;
   localparam logic [7:0] CFG_OFF      = 8'h10;
   // cause register field positions
   localparam int OVF_BIT  = 7;
   localparam int UNF_BIT  = 6;
   localparam int MCLEAR_BIT = 3;
   localparam int INSTR_BIT  = 2;
   localparam int POR_BIT    = 1;
   localparam int BROWN_BIT  = 0;
   // writable/implemented mask of the cause register
   localparam logic [7:0] CAUSE_MASK = 8'hCF;
   // values loaded by a power-on or brown-out event
   localparam logic       STK_FLAG_RST = 1'b0;
   localparam logic       HC_FLAG_RST  = 1'b1;
   localparam logic       PWR_FLAG_RST = 1'b0;
   // config register: stack fault reset enable position and reset value
   localparam int         SFRE_BIT   = 0;
   localparam logic       SFRE_RST   = 1'b1;
   // interrupt status layout: one bit per event
   localparam int EV_OVF  = 0;
   localparam int EV_UNF  = 1;
   localparam int EV_MCLEAR = 2;
   localparam int EV_INSTR  = 3;
   localparam int EV_POR    = 4;
   localparam int EV_BROWN  = 5;
   localparam int NEV     = 6;
endpackage

// ### hdl/rcf_reset_cause_flags.sv
// reset-cause flag register with apb slave and event interrupt
// How it works
// - overflow flag bit 7 set by hardware, held until firmware writes 0 or a power-on/brown-out clears it
// - underflow flag bit 6 set by hardware, held until firmware writes 0 or a power-on/brown-out clears it
// - bits 5 and 4 read zero and ignore writes
// - master-clear reset clears bit 3; firmware may write 1
// - reset instruction clears bit 2; firmware may write 1
// - power-on reset leaves bit 1 at 0; software rewrites 1
// - brown-out or power-on leaves bit 0 at 0; software rewrites 1
// - power-on/brown-out: stack flags 0, clear and instruction flags 1
// - stack flags hardware-set, others hardware-cleared, all firmware read/write
// - stack fault requests reset only when the enable bit is 1
module rcf_reset_cause_flags
   import rcf_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_b,
   // reset generator indications, one-cycle pulses on mclk
   input  wire logic        porEvt,
   input  wire logic        brownEvt,
   input  wire logic        masterClrEvt,
   input  wire logic        rstInstrEvt,
   // stack monitor pulses
   input  wire logic        stack_overflow_flag,
   input  wire logic        stack_underflow_flag,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // stack fault reset request and level interrupt
   output logic             stackResetReq,
   output logic             irq
);

   // register state and next values
   logic [7:0]     cause_q, cause_d;
   logic [NEV-1:0] stat_q, stat_d;
   logic [NEV-1:0] en_q, en_d;
   logic           sfre_q, sfre_d;
   logic [31:0]    rdata_q, rdata_d;
   logic           err_q, err_d;
   logic           acc_q, acc_d;
   // bus decode helpers
   logic           accStart;
   logic           wrEn;
   logic           rdEn;
   logic           known;
   logic           causeWr;
   // event helpers
   logic           pwrEvt;
   logic           stkFault;
   logic [NEV-1:0] evts;

   // apb decode; first access cycle opens the single wait state
   assign accStart = psel && penable && !acc_q;
   // writes land at the edge where pready is seen high
   assign wrEn     = psel && penable && pwrite && acc_q;
   // reads are captured one cycle early so prdata comes from a flop
   assign rdEn     = accStart && !pwrite;
   assign causeWr  = wrEn && (paddr == CAUSE_OFF);
   // unmapped offsets answer with pslverr and read zero
   assign known    = (paddr == CAUSE_OFF)   || (paddr == IRQ_STAT_OFF) ||
                     (paddr == IRQ_CLR_OFF) || (paddr == IRQ_EN_OFF)   ||
                     (paddr == CFG_OFF);

   // bus next values: wait state, error flag, read mux
   always_comb begin
      acc_d   = accStart;
      err_d   = 1'b0;
      rdata_d = rdata_q;
      if (accStart) begin
         err_d = !known;
      end
      if (rdEn) begin
         unique case (paddr)
            CAUSE_OFF:    rdata_d = {24'h00_0000, cause_q & CAUSE_MASK};
            IRQ_STAT_OFF: rdata_d = {26'h000_0000, stat_q};
            IRQ_EN_OFF:   rdata_d = {26'h000_0000, en_q};
            CFG_OFF:      rdata_d = {31'h0000_0000, sfre_q};
            // clear register is write-only, unmapped reads return zero
            default:      rdata_d = 32'h0000_0000;
         endcase
      end
   end

   // bus registers; reset drops any transfer in flight
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         acc_q   <= 1'b0;
         err_q   <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         acc_q   <= acc_d;
         err_q   <= err_d;
         rdata_q <= rdata_d;
      end
   end

   // handshake outputs straight from the wait-state flop
   assign pready  = acc_q;
   assign pslverr = err_q && acc_q;
   assign prdata  = rdata_q;

   // event helpers; status layout follows the package event positions
   assign pwrEvt   = porEvt || brownEvt;
   assign stkFault = stack_overflow_flag || stack_underflow_flag;
   assign evts     = {brownEvt, porEvt, rstInstrEvt, masterClrEvt, stack_underflow_flag, stack_overflow_flag};

   // cause next value; hardware events win over a firmware write
   always_comb begin
      cause_d = cause_q & CAUSE_MASK;
      // firmware reads and writes every implemented flag
      if (causeWr) begin
         cause_d = pwdata[7:0] & CAUSE_MASK;
      end
      if (stack_overflow_flag) begin
         cause_d[OVF_BIT] = 1'b1;
      end
      if (stack_underflow_flag) begin
         cause_d[UNF_BIT] = 1'b1;
      end
      if (masterClrEvt) begin
         cause_d[MCLEAR_BIT] = 1'b0;
      end
      if (rstInstrEvt) begin
         cause_d[INSTR_BIT] = 1'b0;
      end
      if (pwrEvt) begin
         cause_d[OVF_BIT]    = STK_FLAG_RST;
         cause_d[UNF_BIT]    = STK_FLAG_RST;
         cause_d[MCLEAR_BIT] = HC_FLAG_RST;
         cause_d[INSTR_BIT]  = HC_FLAG_RST;
      end
      if (pwrEvt) begin
         cause_d[BROWN_BIT] = PWR_FLAG_RST;
      end
      // power-on flag cleared; a brown-out alone leaves it as it was
      if (porEvt) begin
         cause_d[POR_BIT] = PWR_FLAG_RST;
      end
   end

   // cause flags survive rst_b; only events and firmware change them
   // limitation: undefined until the reset generator pulses porEvt once
   always_ff @(posedge mclk) begin
      cause_q <= cause_d;
   end

   // interrupt status and enable next values
   always_comb begin
      stat_d = stat_q;
      en_d   = en_q;
      // write-one-to-clear; writes to the status offset fall through ignored
      if (wrEn && (paddr == IRQ_CLR_OFF)) begin
         stat_d = stat_q & ~pwdata[NEV-1:0];
      end
      if (wrEn && (paddr == IRQ_EN_OFF)) begin
         en_d = pwdata[NEV-1:0];
      end
      // an event in the clear cycle stays set, so it is never lost
      stat_d = stat_d | evts;
   end

   // status and enable registers
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         stat_q <= '0;
         en_q   <= '0;
      end else begin
         stat_q <= stat_d;
         en_q   <= en_d;
      end
   end

   // stack fault reset enable next value
   always_comb begin
      sfre_d = sfre_q;
      if (wrEn && (paddr == CFG_OFF)) begin
         sfre_d = pwdata[SFRE_BIT];
      end
   end

   // config register; comes out of reset with fault reset enabled
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         sfre_q <= SFRE_RST;
      end else begin
         sfre_q <= sfre_d;
      end
   end

   // fault reset request gated by enable
   assign stackResetReq = sfre_q && stkFault;
   // level interrupt while an enabled status bit is set
   assign irq           = |(stat_q & en_q);

   chk_ovf_sets: assert property (@(posedge mclk)
      stack_overflow_flag && !pwrEvt |=> cause_q[OVF_BIT])
      else $error("overflow flag not set");

   chk_ovf_holds: assert property (@(posedge mclk)
      cause_q[OVF_BIT] && !pwrEvt && !causeWr |=> cause_q[OVF_BIT])
      else $error("overflow flag dropped");

   chk_unf_sets: assert property (@(posedge mclk)
      stack_underflow_flag && !pwrEvt |=> cause_q[UNF_BIT])
      else $error("underflow flag not set");

   chk_unf_holds: assert property (@(posedge mclk)
      cause_q[UNF_BIT] && !pwrEvt && !causeWr |=> cause_q[UNF_BIT])
      else $error("underflow flag dropped");

   chk_unimpl_zero: assert property (@(posedge mclk) disable iff (!rst_b)
      pready && !pwrite && (paddr == CAUSE_OFF) |-> prdata[5:4] == 2'b00)
      else $error("unimplemented bits not zero");

   chk_unimpl_write: assert property (@(posedge mclk)
      causeWr |=> cause_q[5:4] == 2'b00)
      else $error("unimplemented bits written");

   chk_mclear_clears: assert property (@(posedge mclk)
      masterClrEvt && !pwrEvt |=> !cause_q[MCLEAR_BIT])
      else $error("master-clear flag not cleared");

   chk_mclear_rearm: assert property (@(posedge mclk)
      pwrEvt |=> cause_q[MCLEAR_BIT])
      else $error("master-clear flag not re-armed");

   chk_instr_clears: assert property (@(posedge mclk)
      rstInstrEvt && !pwrEvt |=> !cause_q[INSTR_BIT])
      else $error("instruction flag not cleared");

   chk_por_clears: assert property (@(posedge mclk)
      porEvt |=> !cause_q[POR_BIT])
      else $error("power-on flag not cleared");

   chk_brown_keeps: assert property (@(posedge mclk)
      brownEvt && !porEvt && !causeWr |=> cause_q[POR_BIT] == $past(cause_q[POR_BIT]))
      else $error("power-on flag changed by brown-out");

   chk_brown_clears: assert property (@(posedge mclk)
      pwrEvt |=> !cause_q[BROWN_BIT])
      else $error("brown-out flag not cleared");

   chk_pwr_load: assert property (@(posedge mclk)
      pwrEvt |=> (cause_q[7:6] == 2'b00) && (cause_q[3:2] == 2'b11))
      else $error("power-up load wrong");

   chk_flag_write: assert property (@(posedge mclk) disable iff (!rst_b)
      causeWr && !(|evts) |=> cause_q == ($past(pwdata[7:0]) & CAUSE_MASK))
      else $error("firmware write lost");

   chk_fault_gate: assert property (@(posedge mclk)
      stkFault && sfre_q |-> stackResetReq)
      else $error("fault reset missing");

   chk_fault_block: assert property (@(posedge mclk)
      !sfre_q |-> !stackResetReq)
      else $error("fault reset without enable");

   chk_ready_wait: assert property (@(posedge mclk) disable iff (!rst_b)
      accStart |=> pready)
      else $error("ready not after one wait state");

   chk_ready_pulse: assert property (@(posedge mclk) disable iff (!rst_b)
      pready |=> !pready)
      else $error("ready longer than one cycle");

   chk_err_map: assert property (@(posedge mclk) disable iff (!rst_b)
      pready |-> (pslverr == !known))
      else $error("slave error wrong");

   chk_stat_sets: assert property (@(posedge mclk) disable iff (!rst_b)
      (|evts) |=> (stat_q & $past(evts)) == $past(evts))
      else $error("event not captured in status");

endmodule

// ### testbench/rcf_event_model.sv
// model of the reset generator and stack monitor
module rcf_event_model (
   // clock
   input  wire logic       mclk,
   // requested events, msb first: overflow underflow clear instr power brown
   input  wire logic [5:0] evReq,
   // one-cycle pulses toward the block
   output logic            stack_overflow_flag,
   output logic            stack_underflow_flag,
   output logic            masterClrEvt,
   output logic            rstInstrEvt,
   output logic            porEvt,
   output logic            brownEvt
);
   timeunit 1ns;
   timeprecision 1ns;
   // far-side events, one pulse per request
   always_ff @(posedge mclk) begin
      {stack_overflow_flag, stack_underflow_flag, masterClrEvt, rstInstrEvt, porEvt, brownEvt} <= evReq;
   end
endmodule

// ### testbench/test_reset_cause_flags.sv
// self-checking bench of the reset-cause flag block
module test_reset_cause_flags;
   timeunit 1ns;
   timeprecision 1ns;
   import rcf_pkg::*;
   logic mclk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, r;
   logic [5:0] evReq = 6'h00;
   logic pready, pslverr, stackResetReq, irq, stack_overflow_flag, stack_underflow_flag;
   logic masterClrEvt, rstInstrEvt, porEvt, brownEvt;
   logic sfreExp = 1'b1;
   logic [32:0] expQ[$];
   int n_errors = 0, n_compared = 0;
   rcf_reset_cause_flags u_rcf_reset_cause_flags (.*);
   rcf_event_model u_rcf_event_model (.*);
   // 20 MHz clock
   always #25 mclk = ~mclk;
   task automatic check(logic [32:0] got, logic [32:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // one apb transfer, held until pready is seen at an edge
   task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
      int i;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge mclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (i >= 20) begin
         n_errors++;
         print_verdict();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd(logic [7:0] a, logic [32:0] e);
      expQ.push_back(e);
      apb(1'b0, a, 32'h0000_0000);
   endtask
   task automatic ev(logic [5:0] e);
      evReq <= e;
      @(posedge mclk);
      evReq <= 6'h00;
      repeat (2) @(posedge mclk);
   endtask
   task automatic chkIrq(logic e);
      @(posedge mclk);
      #1 check(irq, e); // level follows status and enable
   endtask
   // watcher: read answers against the oldest note, reset request on faults
   always @(posedge mclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) check({pslverr, prdata}, expQ.pop_front());
      if (stack_overflow_flag || stack_underflow_flag) check(stackResetReq, sfreExp);
   end
   initial begin
      void'($urandom(7));
      repeat (8) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      ev(6'h02);
      rd(CAUSE_OFF, 33'h0_0000_000C);
      apb(1'b1, CAUSE_OFF, 32'h0000_003F);
      rd(CAUSE_OFF, 33'h0_0000_000F);
      ev(6'h20);
      rd(CAUSE_OFF, 33'h0_0000_008F);
      ev(6'h10);
      rd(CAUSE_OFF, 33'h0_0000_00CF);
      apb(1'b1, CAUSE_OFF, 32'h0000_000F);
      rd(CAUSE_OFF, 33'h0_0000_000F);
      ev(6'h08);
      rd(CAUSE_OFF, 33'h0_0000_0007);
      ev(6'h04);
      rd(CAUSE_OFF, 33'h0_0000_0003);
      apb(1'b1, CAUSE_OFF, 32'h0000_000F);
      ev(6'h01);
      rd(CAUSE_OFF, 33'h0_0000_000E);
      r = $urandom;
      apb(1'b1, CAUSE_OFF, r);
      rd(CAUSE_OFF, {25'h0, r[7:0] & CAUSE_MASK});
      rd(IRQ_STAT_OFF, 33'h0_0000_003F);
      chkIrq(1'b0);
      apb(1'b1, IRQ_EN_OFF, 32'h0000_003F);
      chkIrq(1'b1);
      apb(1'b1, IRQ_CLR_OFF, 32'h0000_003F);
      rd(IRQ_STAT_OFF, 33'h0_0000_0000);
      chkIrq(1'b0);
      rd(8'h20, 33'h1_0000_0000);
      apb(1'b1, CFG_OFF, 32'h0000_0000);
      sfreExp <= 1'b0;
      ev(6'h30);
      rst_b <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      rd(CAUSE_OFF, {25'h0, (r[7:0] & CAUSE_MASK) | 8'hC0});
      rd(CFG_OFF, 33'h0_0000_0001);
      rd(IRQ_EN_OFF, 33'h0_0000_0000);
      repeat (4) @(posedge mclk);
      print_verdict();
   end
endmodule
